// [src/window_watchdog_timer.sv]
`timescale 1ns/1ps
`default_nettype none

module window_watchdog_timer
(
  input  wire logic                        core_clk,
  input  wire logic                        reset,
  input  wire logic                        wakeupOscClock,
  input  wire logic                        watchdogServiceInstr,
  input  wire logic                        watchdogDisableInstr,
  input  wire logic                        watchdogEnableInstr,
  input  wire logic                        configWrite,
  input  wire logic [wwd_pkg::COUNT_W-1:0] reloadData,
  input  wire logic [wwd_pkg::COUNT_W-1:0] windowData,
  input  wire logic                        clockSourceData,
  input  wire logic                        prescaleData,
  output logic                             resetRequest,
  output logic                             earlyServiceFault,
  output logic                             overflowFault,
  output logic                             watchdogEnabled,
  output logic [wwd_pkg::COUNT_W-1:0]      watchdogCount,
  output logic [wwd_pkg::COUNT_W-1:0]      watchdogReloadValue,
  output logic [wwd_pkg::COUNT_W-1:0]      windowBoundary,
  output logic                             clockSource,
  output logic                             prescaleSelect
);

  wwd_tick_if tickBus ();

  logic                        serviceEarly;
  logic                        overflowNow;
  logic                        countAtTop;
  logic                        belowWindow;
  logic                        countStep;
  logic                        requestPending;
  logic                        next_enabled;
  logic [wwd_pkg::COUNT_W-1:0] next_count;
  logic                        next_resetRequest;
  logic                        next_requestPending;
  logic                        next_earlyServiceFault;
  logic                        next_overflowFault;

  ////////////////////////////////////////////////////////////////////////
  // prescaler
  assign tickBus.srcSelect = clockSource;
  assign tickBus.divSelect = prescaleSelect;
  // held clear while stopped so a restart begins a full prescale period
  assign tickBus.clear     = ~watchdogEnabled;

  wwd_prescaler prescaler
  (
    .core_clk       (core_clk),
    .reset          (reset),
    .wakeupOscClock (wakeupOscClock),
    .tickBus        (tickBus)
  );

  ////////////////////////////////////////////////////////////////////////
  // configuration registers; one strobe loads all four together
  always_ff @(posedge core_clk)
  begin
    if (reset)
      watchdogReloadValue <= wwd_pkg::RELOAD_RST;
    else if (configWrite)
      watchdogReloadValue <= reloadData;
  end

  // reset value 0 leaves the window open, so no service is early
  always_ff @(posedge core_clk)
  begin
    if (reset)
      windowBoundary <= wwd_pkg::WINDOW_RST;
    else if (configWrite)
      windowBoundary <= windowData;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      clockSource <= wwd_pkg::SRC_RST;
    else if (configWrite)
      clockSource <= clockSourceData;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      prescaleSelect <= wwd_pkg::DIV_RST;
    else if (configWrite)
      prescaleSelect <= prescaleData;
  end

  ////////////////////////////////////////////////////////////////////////
  // enable; enable wins if both instructions land together
  always_comb
  begin
    next_enabled = watchdogEnabled;
    if (watchdogDisableInstr)
      next_enabled = 1'b0;
    if (watchdogEnableInstr)
      next_enabled = 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      watchdogEnabled <= 1'b1;
    else
      watchdogEnabled <= next_enabled;
  end

  ////////////////////////////////////////////////////////////////////////
  // fault detection; window only policed while running
  // a service while stopped reloads and clears the cause flags but never faults; the window needs a running count
  assign countAtTop   = (watchdogCount == wwd_pkg::COUNT_ALL_ONES);
  assign belowWindow  = (watchdogCount < windowBoundary);
  assign countStep    = watchdogEnabled && tickBus.tick;
  assign serviceEarly = watchdogEnabled && watchdogServiceInstr && belowWindow;
  // a coincident service wins, so a timely service at the top never faults
  assign overflowNow  = countStep && !watchdogServiceInstr && countAtTop;

  ////////////////////////////////////////////////////////////////////////
  // counter; service takes priority over a coincident tick
  // keeps running after a wrap; acting on the request is left to the chip
  always_comb
  begin
    next_count = watchdogCount;
    if (watchdogServiceInstr)
      next_count = watchdogReloadValue;
    else if (countStep)
      next_count = watchdogCount + wwd_pkg::COUNT_STEP;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      watchdogCount <= wwd_pkg::RELOAD_RST;
    else
      watchdogCount <= next_count;
  end

  ////////////////////////////////////////////////////////////////////////
  // one request pulse per event; an event landing on a live pulse waits
  // one cycle so the pulses stay apart (a third in a row merges)
  always_comb
  begin
    next_resetRequest   = 1'b0;
    next_requestPending = 1'b0;
    if (serviceEarly || overflowNow || requestPending)
    begin
      if (resetRequest)
        next_requestPending = 1'b1;
      else
        next_resetRequest = 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      resetRequest <= 1'b0;
    else
      resetRequest <= next_resetRequest;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      requestPending <= 1'b0;
    else
      requestPending <= next_requestPending;
  end

  ////////////////////////////////////////////////////////////////////////
  // cause flags hold until the next service; set beats the clear
  always_comb
  begin
    next_earlyServiceFault = earlyServiceFault;
    if (watchdogServiceInstr)
      next_earlyServiceFault = 1'b0;
    if (serviceEarly)
      next_earlyServiceFault = 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      earlyServiceFault <= 1'b0;
    else
      earlyServiceFault <= next_earlyServiceFault;
  end

  always_comb
  begin
    next_overflowFault = overflowFault;
    if (watchdogServiceInstr)
      next_overflowFault = 1'b0;
    if (overflowNow)
      next_overflowFault = 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      overflowFault <= 1'b0;
    else
      overflowFault <= next_overflowFault;
  end

endmodule : window_watchdog_timer

`default_nettype wire

// [src/wwd_pkg.sv]
package wwd_pkg;

  localparam int unsigned COUNT_W = 16;
  localparam int unsigned PRE_W   = 14;

  // counter limits
  localparam logic [COUNT_W-1:0] COUNT_ALL_ONES = 16'hFFFF;
  localparam logic [COUNT_W-1:0] COUNT_ZERO     = 16'h0000;
  localparam logic [COUNT_W-1:0] COUNT_STEP     = 16'h0001;

  // prescaler terminal values: divide by 16384 or 256
  localparam logic [PRE_W-1:0] PRE_LONG_TOP  = 14'h3FFF;
  localparam logic [PRE_W-1:0] PRE_SHORT_TOP = 14'h00FF;
  localparam logic [PRE_W-1:0] PRE_ZERO      = 14'h0000;
  localparam logic [PRE_W-1:0] PRE_STEP      = 14'h0001;

  // select encodings
  localparam logic SRC_SYSTEM = 1'b0;
  localparam logic SRC_WAKEUP = 1'b1;
  localparam logic DIV_SHORT  = 1'b0;
  localparam logic DIV_LONG   = 1'b1;

  // defaults: 4 ticks of 16384 wake-up periods at 500 kHz, about 0.131 s
  localparam logic [COUNT_W-1:0] RELOAD_RST = 16'hFFFC;
  localparam logic [COUNT_W-1:0] WINDOW_RST = 16'h0000;
  localparam logic               SRC_RST    = SRC_WAKEUP;
  localparam logic               DIV_RST    = DIV_LONG;

endpackage : wwd_pkg

// [src/wwd_tick_if.sv]
`timescale 1ns/1ps
`default_nettype none

interface wwd_tick_if;
  logic srcSelect;
  logic divSelect;
  logic clear;
  logic tick;

  modport source
  (
    input  srcSelect,
    input  divSelect,
    input  clear,
    output tick
  );

  modport sink
  (
    output srcSelect,
    output divSelect,
    output clear,
    input  tick
  );
endinterface : wwd_tick_if

`default_nettype wire

// [src/wwd_prescaler.sv]
`timescale 1ns/1ps
`default_nettype none

module wwd_prescaler
(
  input  wire logic   core_clk,
  input  wire logic   reset,
  input  wire logic   wakeupOscClock,
  wwd_tick_if.source  tickBus
);

  logic                      wakeupLevel;
  logic                      sourceStep;
  logic [wwd_pkg::PRE_W-1:0] preCount;
  logic [wwd_pkg::PRE_W-1:0] preTop;

  ////////////////////////////////////////////////////////////////////////
  // wake-up clock arrives as a synchronous level; count its rising edges
  // no reset: it tracks the pin through reset, so release brings no false edge
  always_ff @(posedge core_clk)
  begin
    wakeupLevel <= wakeupOscClock;
  end

  assign sourceStep = (tickBus.srcSelect == wwd_pkg::SRC_SYSTEM) ? 1'b1
                    : (wakeupOscClock & ~wakeupLevel);

  assign preTop = (tickBus.divSelect == wwd_pkg::DIV_LONG) ? wwd_pkg::PRE_LONG_TOP
                                                           : wwd_pkg::PRE_SHORT_TOP;

  ////////////////////////////////////////////////////////////////////////
  // divider; switching divide ratio mid-count just wraps early or late once
  always_ff @(posedge core_clk)
  begin
    if (reset || tickBus.clear)
      preCount <= wwd_pkg::PRE_ZERO;
    else if (sourceStep)
    begin
      if (preCount >= preTop)
        preCount <= wwd_pkg::PRE_ZERO;
      else
        preCount <= preCount + wwd_pkg::PRE_STEP;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset || tickBus.clear)
      tickBus.tick <= 1'b0;
    else
      tickBus.tick <= sourceStep && (preCount >= preTop);
  end

endmodule : wwd_prescaler

`default_nettype wire

// [verification/wwd_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module wwd_chk
(
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic        watchdogServiceInstr,
  input wire logic        watchdogDisableInstr,
  input wire logic        watchdogEnableInstr,
  input wire logic        resetRequest,
  input wire logic        earlyServiceFault,
  input wire logic        overflowFault,
  input wire logic        watchdogEnabled,
  input wire logic [15:0] watchdogCount,
  input wire logic [15:0] watchdogReloadValue,
  input wire logic [15:0] windowBoundary
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////
  // checked through reset itself, so no disable here
  a_reset_state:
    assert property (disable iff (1'b0) reset |=> watchdogEnabled && watchdogCount == wwd_pkg::RELOAD_RST)
    else $error("bad state after reset");
  a_req_single:
    assert property (resetRequest |=> !resetRequest) else $error("request longer than one cycle");
  a_req_cause:
    assert property (resetRequest |-> overflowFault || earlyServiceFault) else $error("request without cause");
  a_wrap_overflow:
    assert property ($rose(overflowFault) |-> resetRequest && watchdogCount == 16'h0000
      && $past(watchdogCount) == 16'hFFFF) else $error("overflow not at wrap");
  a_early_service:
    assert property (watchdogServiceInstr && watchdogEnabled && !watchdogDisableInstr
      && watchdogCount < windowBoundary |=> resetRequest && earlyServiceFault) else $error("early service missed");
  a_service_load:
    assert property (watchdogServiceInstr |=> watchdogCount == $past(watchdogReloadValue)) else $error("no reload");
  a_disable_stop:
    assert property (watchdogDisableInstr && !watchdogEnableInstr |=> !watchdogEnabled) else $error("not disabled");
  a_enable_start:
    assert property (watchdogEnableInstr |=> watchdogEnabled) else $error("not enabled");
  a_count_step:
    assert property (!$past(watchdogServiceInstr) && $changed(watchdogCount)
      |-> watchdogCount == $past(watchdogCount) + 16'h0001) else $error("count skipped");
  cover property (overflowFault && resetRequest);
  cover property (earlyServiceFault && resetRequest);
  cover property (!watchdogEnabled);
  cover property (watchdogDisableInstr && watchdogEnableInstr);
endmodule : wwd_chk
`default_nettype wire

// [verification/tb_window_watchdog_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_window_watchdog_timer;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic        wakeupOscClock = 1'b0;
  logic        watchdogServiceInstr = 1'b0;
  logic        watchdogDisableInstr = 1'b0;
  logic        watchdogEnableInstr = 1'b0;
  logic        configWrite = 1'b0;
  logic [15:0] reloadData = 16'h0000;
  logic [15:0] windowData = 16'h0000;
  logic        clockSourceData = 1'b0;
  logic        prescaleData = 1'b0;
  logic        resetRequest, earlyServiceFault, overflowFault, watchdogEnabled, clockSource, prescaleSelect;
  logic [15:0] watchdogCount, watchdogReloadValue, windowBoundary;
  int          fail_count = 0;
  int          checked = 0;
  int          cyc = 0;
  int          n;
  localparam logic [3:0] CFG = 4'h8;
  localparam logic [3:0] SRV = 4'h4;
  localparam logic [3:0] DIS = 4'h2;
  localparam logic [3:0] ENA = 4'h1;
  window_watchdog_timer i_dut (.*);
  ////////////////////////////////////////////////////////////////
  initial forever #2.5 core_clk = ~core_clk;
  // wake-up clock of 8 cycles keeps the slow path short
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    wakeupOscClock <= cyc[2];
    if (cyc == 40000)
    begin
      fail_count++;
      report_and_stop();
    end
  end
  task report_and_stop();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  task chk(string name, logic [15:0] exp, logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", name, exp, got);
    end
  endtask : chk
  task pulse(logic [3:0] sel);
    @(posedge core_clk);
    {configWrite, watchdogServiceInstr, watchdogDisableInstr, watchdogEnableInstr} <= sel;
    @(posedge core_clk);
    {configWrite, watchdogServiceInstr, watchdogDisableInstr, watchdogEnableInstr} <= 4'h0;
    @(negedge core_clk);
  endtask : pulse
  task cfg(logic [15:0] rl, logic [15:0] wn, logic src, logic div);
    @(posedge core_clk);
    {reloadData, windowData, clockSourceData, prescaleData} <= {rl, wn, src, div};
    pulse(CFG);
  endtask : cfg
  task wreq(int lim);
    n = 0;
    while (resetRequest !== 1'b1 && n < lim)
    begin
      @(negedge core_clk);
      n++;
    end
  endtask : wreq
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    @(negedge core_clk);
    chk("enabled", 16'h0001, watchdogEnabled);
    chk("count", wwd_pkg::RELOAD_RST, watchdogCount);
    chk("reload", wwd_pkg::RELOAD_RST, watchdogReloadValue);
    chk("select", 16'h0003, {clockSource, prescaleSelect});
    chk("window", 16'h0000, windowBoundary);
    cfg(16'hFFFE, 16'h0000, wwd_pkg::SRC_SYSTEM, wwd_pkg::DIV_SHORT);
    chk("select", 16'h0000, {clockSource, prescaleSelect});
    pulse(SRV);
    chk("count", 16'hFFFE, watchdogCount);
    wreq(800);
    chk("overflow time", 16'h0001, n >= 256 && n <= 530);
    chk("wrap count", 16'h0000, watchdogCount);
    chk("overflow flag", 16'h0001, overflowFault);
    @(negedge core_clk);
    chk("pulse end", 16'h0000, resetRequest);
    cfg(16'hFFF0, 16'h8000, wwd_pkg::SRC_SYSTEM, wwd_pkg::DIV_SHORT);
    chk("window", 16'h8000, windowBoundary);
    chk("reload", 16'hFFF0, watchdogReloadValue);
    pulse(SRV);
    chk("early req", 16'h0001, resetRequest);
    chk("early flag", 16'h0001, earlyServiceFault);
    chk("count", 16'hFFF0, watchdogCount);
    pulse(SRV);
    chk("late req", 16'h0000, resetRequest);
    chk("early flag", 16'h0000, earlyServiceFault);
    pulse(DIS);
    chk("enabled", 16'h0000, watchdogEnabled);
    pulse(SRV);
    wreq(1200);
    chk("frozen", 16'hFFF0, watchdogCount);
    chk("no request", 16'h0001, n == 1200);
    pulse(DIS | ENA);
    chk("enable wins", 16'h0001, watchdogEnabled);
    wreq(4300);
    chk("short divide", 16'h0001, n >= 4090 && n <= 4110);
    pulse(DIS);
    cfg(16'hFFFF, 16'h0000, wwd_pkg::SRC_SYSTEM, wwd_pkg::DIV_LONG);
    pulse(SRV);
    pulse(ENA);
    wreq(17000);
    chk("long divide", 16'h0001, n >= 16380 && n <= 16400);
    pulse(DIS);
    cfg(16'hFFFF, 16'h0000, wwd_pkg::SRC_WAKEUP, wwd_pkg::DIV_SHORT);
    pulse(SRV);
    pulse(ENA);
    wreq(3000);
    chk("wakeup source", 16'h0001, n >= 2030 && n <= 2070);
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    @(negedge core_clk);
    chk("enabled", 16'h0001, watchdogEnabled);
    chk("count", wwd_pkg::RELOAD_RST, watchdogCount);
    chk("select", 16'h0003, {clockSource, prescaleSelect});
    chk("flags", 16'h0000, {resetRequest, earlyServiceFault, overflowFault});
    report_and_stop();
  end
endmodule : tb_window_watchdog_timer
bind window_watchdog_timer wwd_chk i_chk (.*);
`default_nettype wire
